// >>> logic/mwu_regs.vh
// register map, field positions and timing constants of the wakeup block
`ifndef MWU_REGS_VH
`define MWU_REGS_VH

`define MWU_OFF_L_EN 8'h00
`define MWU_OFF_L_EDGE 8'h04
`define MWU_OFF_L_PEND 8'h08
`define MWU_OFF_M_EN 8'h0C
`define MWU_OFF_M_EDGE 8'h10
`define MWU_OFF_M_PEND 8'h14
`define MWU_OFF_CTRL 8'h18
`define MWU_OFF_STAT 8'h1C

`define MWU_REG_RST 8'h00
`define MWU_WORD_ZERO 32'h00000000
`define MWU_PAD_24 24'h000000
`define MWU_PAD_26 26'h0000000

`define MWU_CTRL_PIE 0
`define MWU_CTRL_GIE 1
`define MWU_CTRL_HALT 2
`define MWU_CTRL_IDLE 3

`define MWU_STAT_RUN 0
`define MWU_STAT_HALT 1
`define MWU_STAT_IDLE 2
`define MWU_STAT_WAKE 3
`define MWU_STAT_SERVICE 4
`define MWU_STAT_REFUSED 5

`define MWU_CAN_BIT 7
`define MWU_TC_DIV_LAST 4'h9
`define MWU_TC_DIV_ZERO 4'h0
`define MWU_TC_DIV_ONE 4'h1
`define MWU_IDLE_LOAD 9'h100
`define MWU_IDLE_ONE 9'h001
`define MWU_IDLE_ZERO 9'h000
`define MWU_HTRANS_ACTIVE 1
`define MWU_HRESP_OKAY 1'h0

`endif

// >>> logic/mwu_edge.v
// per-pin sampling and edge detection for one eight-pin port
`timescale 1ns/100ps
module mwu_edge
(
    input wire clk_sys_i,
    input wire rst_i,
    input wire tc_en_i,
    input wire [7:0] pins_i,
    input wire [7:0] edge_sel_i,
    output wire [7:0] hit_o
);
`include "mwu_regs.vh"

genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_pin
        reg cur_ff;
        reg prev_ff;
        reg hit_ff;
        wire nxt_hit;
        // edge select high means falling edge, low means rising edge
        assign nxt_hit = tc_en_i & (edge_sel_i[gi] ? (prev_ff & ~cur_ff) : (~prev_ff & cur_ff));
        always @(posedge clk_sys_i or posedge rst_i)
        begin
            if (rst_i)
            begin
                cur_ff <= 1'b0;
                prev_ff <= 1'b0;
                hit_ff <= 1'b0;
            end
            else
            begin
                // samples move only on the instruction clock, one hit per edge
                if (tc_en_i)
                begin
                    cur_ff <= pins_i[gi];
                    prev_ff <= cur_ff;
                end
                hit_ff <= nxt_hit;
            end
        end
        assign hit_o[gi] = hit_ff;
    end
endgenerate

endmodule // mwu_edge

// >>> logic/mwu_top.v
// multi-input wakeup and port interrupt block with AHB-Lite register slave
// Contract
// - eight-bit wake enable register per port
// - edge select bit picks falling or rising
// - selected edge sets pending until software clears
// - halt request ignored while enabled pending exists
// - enable, edge, pending readable, writable, reset zero
// - port L eight sources share one interrupt
// - interrupt needs port and global enable
// - port M seven sources share one interrupt
// - port L wake resumes or services first
// - wake runs idle timer 256 instruction clocks
// - port M wake resumes or services first
// - CAN wake raises no port interrupt
// - CAN transition sets pending bit 7, wakes
// - edge select bit 7 picks CAN edge
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
module mwu_top
(
    input wire clk_sys_i,
    input wire rst_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output wire [31:0] hrdata_o,
    output wire hreadyout_o,
    output wire hresp_o,
    input wire [7:0] port_l_pins_i,
    input wire [6:0] port_m_pins_i,
    input wire can_receive_input_primary_i,
    output wire irq_port_l_o,
    output wire irq_port_m_o,
    output wire core_clock_enable_o,
    output wire osc_enable_o,
    output wire resume_service_o
);
`include "mwu_regs.vh"

localparam [3:0] ST_RUN = 4'h1;
localparam [3:0] ST_HALT = 4'h2;
localparam [3:0] ST_IDLE = 4'h4;
localparam [3:0] ST_WAKE = 4'h8;

// register-file state
reg [7:0] port_l_wake_enable_ff;
reg [7:0] port_l_wake_edge_select_ff;
reg [7:0] port_l_wake_pending_ff;
reg [7:0] port_m_wake_enable_ff;
reg [7:0] port_m_wake_edge_select_ff;
reg [7:0] port_m_wake_pending_ff;
reg port_interrupt_enable_ff;
reg global_interrupt_enable_ff;
reg [7:0] nxt_l_en;
reg [7:0] nxt_l_edge;
reg [7:0] nxt_l_pend;
reg [7:0] nxt_m_en;
reg [7:0] nxt_m_edge;
reg [7:0] nxt_m_pend;
reg nxt_pie;
reg nxt_gie;
// bus state
reg wr_pend_ff;
reg [7:0] wr_addr_ff;
reg [31:0] hrdata_ff;
reg hreadyout_ff;
reg hresp_ff;
reg [31:0] nxt_hrdata;
// power and timing state
reg [3:0] tc_div_ff;
reg tc_en_ff;
reg [3:0] state_ff;
reg [3:0] nxt_state;
reg [8:0] idle_cnt_ff;
reg [8:0] nxt_idle_cnt;
reg service_ff;
reg nxt_service;
reg refused_ff;
reg nxt_refused;
reg core_clk_en_ff;
reg osc_en_ff;
reg irq_l_ff;
reg irq_m_ff;
wire [7:0] l_hit;
wire [7:0] m_hit;
wire [7:0] m_pins;
wire addr_sel;
wire wr_l_en;
wire wr_l_edge;
wire wr_l_pend;
wire wr_m_en;
wire wr_m_edge;
wire wr_m_pend;
wire wr_ctrl;
wire halt_req;
wire idle_req;
wire wake_any;
wire irq_l_req;
wire irq_m_req;
wire [7:0] stat_word;

function wr_hit;
    input pend;
    input [7:0] addr;
    input [7:0] off;
    begin
        wr_hit = pend & (addr == off);
    end
endfunction

function [7:0] rd_byte;
    input [7:0] addr;
    input [7:0] l_en;
    input [7:0] l_edge;
    input [7:0] l_pend;
    input [7:0] m_en;
    input [7:0] m_edge;
    input [7:0] m_pend;
    input [7:0] ctrl;
    input [7:0] stat;
    begin
        case (addr)
            `MWU_OFF_L_EN: rd_byte = l_en;
            `MWU_OFF_L_EDGE: rd_byte = l_edge;
            `MWU_OFF_L_PEND: rd_byte = l_pend;
            `MWU_OFF_M_EN: rd_byte = m_en;
            `MWU_OFF_M_EDGE: rd_byte = m_edge;
            `MWU_OFF_M_PEND: rd_byte = m_pend;
            `MWU_OFF_CTRL: rd_byte = ctrl;
            `MWU_OFF_STAT: rd_byte = stat;
            default: rd_byte = `MWU_REG_RST;
        endcase
    end
endfunction

// pin 7 of port M is the CAN receive line
assign m_pins = {can_receive_input_primary_i, port_m_pins_i};

mwu_edge u_edge_l
(
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .tc_en_i(tc_en_ff),
    .pins_i(port_l_pins_i),
    .edge_sel_i(port_l_wake_edge_select_ff),
    .hit_o(l_hit)
);

mwu_edge u_edge_m
(
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .tc_en_i(tc_en_ff),
    .pins_i(m_pins),
    .edge_sel_i(port_m_wake_edge_select_ff),
    .hit_o(m_hit)
);

// bus decode; zero wait states, so the data phase is always the next cycle
assign addr_sel = hsel_i & htrans_i[`MWU_HTRANS_ACTIVE] & hready_i;
assign wr_l_en = wr_hit(wr_pend_ff, wr_addr_ff, `MWU_OFF_L_EN);
assign wr_l_edge = wr_hit(wr_pend_ff, wr_addr_ff, `MWU_OFF_L_EDGE);
assign wr_l_pend = wr_hit(wr_pend_ff, wr_addr_ff, `MWU_OFF_L_PEND);
assign wr_m_en = wr_hit(wr_pend_ff, wr_addr_ff, `MWU_OFF_M_EN);
assign wr_m_edge = wr_hit(wr_pend_ff, wr_addr_ff, `MWU_OFF_M_EDGE);
assign wr_m_pend = wr_hit(wr_pend_ff, wr_addr_ff, `MWU_OFF_M_PEND);
assign wr_ctrl = wr_hit(wr_pend_ff, wr_addr_ff, `MWU_OFF_CTRL);
assign halt_req = wr_ctrl & hwdata_i[`MWU_CTRL_HALT];
assign idle_req = wr_ctrl & hwdata_i[`MWU_CTRL_IDLE];

// any enabled and pending pin, CAN bit included, wakes and blocks halt
assign wake_any = (|(port_l_wake_enable_ff & port_l_wake_pending_ff)) |
                  (|(port_m_wake_enable_ff & port_m_wake_pending_ff));

// CAN bit 7 is left out of the port M request
assign irq_l_req = port_interrupt_enable_ff & global_interrupt_enable_ff &
                   (|(port_l_wake_enable_ff & port_l_wake_pending_ff));
assign irq_m_req = port_interrupt_enable_ff & global_interrupt_enable_ff &
                   (|(port_m_wake_enable_ff[6:0] & port_m_wake_pending_ff[6:0]));

always @*
begin
    nxt_l_en = wr_l_en ? hwdata_i[7:0] : port_l_wake_enable_ff;
    nxt_l_edge = wr_l_edge ? hwdata_i[7:0] : port_l_wake_edge_select_ff;
    nxt_m_en = wr_m_en ? hwdata_i[7:0] : port_m_wake_enable_ff;
    nxt_m_edge = wr_m_edge ? hwdata_i[7:0] : port_m_wake_edge_select_ff;
    // a new edge wins over a software clear in the same cycle
    nxt_l_pend = (wr_l_pend ? hwdata_i[7:0] : port_l_wake_pending_ff) | l_hit;
    nxt_m_pend = (wr_m_pend ? hwdata_i[7:0] : port_m_wake_pending_ff) | m_hit;
    nxt_pie = wr_ctrl ? hwdata_i[`MWU_CTRL_PIE] : port_interrupt_enable_ff;
    nxt_gie = wr_ctrl ? hwdata_i[`MWU_CTRL_GIE] : global_interrupt_enable_ff;
    // power state machine
    nxt_state = state_ff;
    nxt_idle_cnt = idle_cnt_ff;
    nxt_service = service_ff;
    nxt_refused = refused_ff;
    case (state_ff)
        ST_RUN:
        begin
            if (halt_req)
            begin
                // the halt write is dropped while a wake source is pending
                nxt_refused = wake_any;
                if (!wake_any)
                begin
                    nxt_state = ST_HALT;
                    nxt_service = 1'b0;
                end
            end
            else if (idle_req)
            begin
                nxt_state = ST_IDLE;
                nxt_service = 1'b0;
            end
        end
        ST_HALT, ST_IDLE:
        begin
            if (wake_any)
            begin
                nxt_state = ST_WAKE;
                nxt_idle_cnt = `MWU_IDLE_LOAD;
            end
        end
        ST_WAKE:
        begin
            if (tc_en_ff)
            begin
                nxt_idle_cnt = idle_cnt_ff - `MWU_IDLE_ONE;
                if (idle_cnt_ff == `MWU_IDLE_ONE)
                begin
                    nxt_state = ST_RUN;
                    // interrupt enabled: service routine first, else plain resume
                    nxt_service = irq_l_req | irq_m_req;
                end
            end
        end
        default:
        begin
            nxt_state = ST_RUN;
            nxt_idle_cnt = `MWU_IDLE_ZERO;
        end
    endcase
end

assign stat_word = {2'b00, refused_ff, service_ff, state_ff[3], state_ff[2], state_ff[1], state_ff[0]};
// read data built from next values so a read right after a write sees it
always @*
begin
    nxt_hrdata = hrdata_ff;
    if (addr_sel && !hwrite_i)
    begin
        nxt_hrdata = {`MWU_PAD_24, rd_byte(haddr_i[7:0], nxt_l_en, nxt_l_edge, nxt_l_pend,
                                          nxt_m_en, nxt_m_edge, nxt_m_pend,
                                          {6'b000000, nxt_gie, nxt_pie}, stat_word)};
    end
end
always @(posedge clk_sys_i or posedge rst_i)
begin
    if (rst_i)
    begin
        port_l_wake_enable_ff <= `MWU_REG_RST;
        port_l_wake_edge_select_ff <= `MWU_REG_RST;
        port_l_wake_pending_ff <= `MWU_REG_RST;
        port_m_wake_enable_ff <= `MWU_REG_RST;
        port_m_wake_edge_select_ff <= `MWU_REG_RST;
        port_m_wake_pending_ff <= `MWU_REG_RST;
        port_interrupt_enable_ff <= 1'b0;
        global_interrupt_enable_ff <= 1'b0;
        wr_pend_ff <= 1'b0;
        wr_addr_ff <= `MWU_REG_RST;
        hrdata_ff <= `MWU_WORD_ZERO;
        hreadyout_ff <= 1'b1;
        hresp_ff <= `MWU_HRESP_OKAY;
        tc_div_ff <= `MWU_TC_DIV_ZERO;
        tc_en_ff <= 1'b0;
        state_ff <= ST_RUN;
        idle_cnt_ff <= `MWU_IDLE_ZERO;
        service_ff <= 1'b0;
        refused_ff <= 1'b0;
        core_clk_en_ff <= 1'b1;
        osc_en_ff <= 1'b1;
        irq_l_ff <= 1'b0;
        irq_m_ff <= 1'b0;
    end
    else
    begin
        port_l_wake_enable_ff <= nxt_l_en;
        port_l_wake_edge_select_ff <= nxt_l_edge;
        port_l_wake_pending_ff <= nxt_l_pend;
        port_m_wake_enable_ff <= nxt_m_en;
        port_m_wake_edge_select_ff <= nxt_m_edge;
        port_m_wake_pending_ff <= nxt_m_pend;
        port_interrupt_enable_ff <= nxt_pie;
        global_interrupt_enable_ff <= nxt_gie;
        wr_pend_ff <= addr_sel & hwrite_i;
        wr_addr_ff <= haddr_i[7:0];
        hrdata_ff <= nxt_hrdata;
        hreadyout_ff <= 1'b1;
        hresp_ff <= `MWU_HRESP_OKAY;
        // instruction clock enable; free running, one clock only so it keeps counting in halt
        tc_div_ff <= (tc_div_ff == `MWU_TC_DIV_LAST) ? `MWU_TC_DIV_ZERO : tc_div_ff + `MWU_TC_DIV_ONE;
        tc_en_ff <= (tc_div_ff == `MWU_TC_DIV_LAST);
        state_ff <= nxt_state;
        idle_cnt_ff <= nxt_idle_cnt;
        service_ff <= nxt_service;
        refused_ff <= nxt_refused;
        // core clock held off until the idle timer has run out; oscillator off only in halt
        core_clk_en_ff <= (nxt_state == ST_RUN);
        osc_en_ff <= (nxt_state != ST_HALT);
        irq_l_ff <= irq_l_req;
        irq_m_ff <= irq_m_req;
    end
end

assign hrdata_o = hrdata_ff;
assign hreadyout_o = hreadyout_ff;
assign hresp_o = hresp_ff;
assign irq_port_l_o = irq_l_ff;
assign irq_port_m_o = irq_m_ff;
assign core_clock_enable_o = core_clk_en_ff;
assign osc_enable_o = osc_en_ff;
assign resume_service_o = service_ff;
endmodule // mwu_top

// >>> tb/mwu_chk.sv
// port-level assertions for the wakeup block
`timescale 1ns/100ps
module mwu_chk
(
    input wire clk_sys_i,
    input wire rst_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    input wire [31:0] hrdata_o,
    input wire hreadyout_o,
    input wire hresp_o,
    input wire irq_port_l_o,
    input wire irq_port_m_o,
    input wire core_clock_enable_o,
    input wire osc_enable_o,
    input wire resume_service_o
);
    reg wr_ctrl_ff;
    reg [1:0] ie_ff;
    reg [11:0] wait_ff;
    wire take = hsel_i & htrans_i[1] & hready_i;
    // ctrl copy rebuilt from bus traffic, since the checker cannot see registers
    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ctrl_ff <= 1'b0;
            ie_ff <= 2'h0;
            wait_ff <= 12'h000;
        end
        else
        begin
            wr_ctrl_ff <= take & hwrite_i & (haddr_i[7:0] == 8'h18);
            if (wr_ctrl_ff)
                ie_ff <= hwdata_i[1:0];
            wait_ff <= (osc_enable_o & !core_clock_enable_o) ? wait_ff + 12'h001 : 12'h000;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence osc_back;
        !osc_enable_o ##1 osc_enable_o;
    endsequence
    sequence sleep_entry;
        $fell(core_clock_enable_o);
    endsequence
    bus_okay_a: assert property (!hresp_o && hreadyout_o)
        else $error("bus response not okay");
    byte_wide_a: assert property (hrdata_o[31:8] == 24'h000000)
        else $error("read data above bit 7");
    rdata_hold_a: assert property (!(take && !hwrite_i) |=> $stable(hrdata_o))
        else $error("read data changed without read");
    irq_l_gate_a: assert property (irq_port_l_o |-> ie_ff == 2'h3 || $past(ie_ff) == 2'h3)
        else $error("port l irq without both enables");
    irq_m_gate_a: assert property (irq_port_m_o |-> ie_ff == 2'h3 || $past(ie_ff) == 2'h3)
        else $error("port m irq without both enables");
    halt_stop_a: assert property (!osc_enable_o |-> !core_clock_enable_o)
        else $error("core clock while oscillator off");
    wake_hold_a: assert property (osc_back |=> !core_clock_enable_o [*8])
        else $error("core clock too soon after wake");
    wake_delay_a: assert property ($rose(core_clock_enable_o) |-> wait_ff >= 12'h9F6)
        else $error("idle timer delay too short");
    resume_sync_a: assert property ($rose(resume_service_o) |-> ##[0:2] core_clock_enable_o)
        else $error("service flag without core clock");
    sleep_clear_a: assert property (sleep_entry |-> ##[0:1] !resume_service_o)
        else $error("service flag kept on sleep");
endmodule // mwu_chk
bind mwu_top mwu_chk chk_i (.clk_sys_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i,
    .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .irq_port_l_o, .irq_port_m_o,
    .core_clock_enable_o, .osc_enable_o, .resume_service_o);

// >>> tb/mwu_pin_model.sv
// outside world: port pins and CAN receive line
`timescale 1ns/100ps
module mwu_pin_model
(
    input wire clk_sys_i,
    input wire [15:0] want_i,
    input wire [1:0] lag_i,
    output reg [7:0] port_l_o = 8'h00,
    output reg [7:0] port_m_o = 8'h00
);
    reg [1:0] cnt_ff = 2'h0;
    // slow answers: a level reaches the pins up to three clocks late
    always @(posedge clk_sys_i)
    begin
        if (cnt_ff == 2'h0)
        begin
            {port_m_o, port_l_o} <= want_i;
            cnt_ff <= lag_i;
        end
        else
            cnt_ff <= cnt_ff - 2'h1;
    end
endmodule // mwu_pin_model

// >>> tb/multi_input_wakeup_irq_tb_top.sv
// self-checking bench for the wakeup block
`timescale 1ns/100ps
module multi_input_wakeup_irq_tb_top;
    reg clk_sys_i = 1'b0;
    reg rst_i = 1'b1;
    reg hsel = 1'b0;
    reg [31:0] haddr = 32'h00000000;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [31:0] hwdata = 32'h00000000;
    reg [15:0] want = 16'h0000;
    reg [1:0] lag = 2'h0;
    reg [15:0] p0, p1, e;
    reg [31:0] rd;
    reg [7:0] mdl [0:7];
    wire [31:0] hrdata;
    wire [7:0] pl, pm;
    wire hready, irq_l, irq_m, cce, osc, svc;
    integer mismatches = 0;
    integer n_checks = 0;
    integer seed = 32'h1a2a;
    integer i, k;
    always #10 clk_sys_i = ~clk_sys_i;
    mwu_top uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(), .port_l_pins_i(pl), .port_m_pins_i(pm[6:0]),
        .can_receive_input_primary_i(pm[7]), .irq_port_l_o(irq_l), .irq_port_m_o(irq_m),
        .core_clock_enable_o(cce), .osc_enable_o(osc), .resume_service_o(svc));
    mwu_pin_model pins (.clk_sys_i(clk_sys_i), .want_i(want), .lag_i(lag), .port_l_o(pl), .port_m_o(pm));
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", n_checks, mismatches);
            if (mismatches == 0 && n_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task check(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp)
            begin
                mismatches = mismatches + 1;
                $display("ERROR %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wait_rdy;
        integer n;
        begin
            n = 0;
            @(posedge clk_sys_i);
            while (hready !== 1'b1 && n < 50)
            begin
                n = n + 1;
                @(posedge clk_sys_i);
            end
            if (n >= 50)
            begin
                mismatches = mismatches + 1;
                complete_run;
            end
        end
    endtask
    task bus(input wr, input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_sys_i);
            hsel <= 1'b1;
            htrans <= 2'h2;
            hwrite <= wr;
            haddr <= {24'h000000, a};
            wait_rdy;
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= {24'h000000, d};
            wait_rdy;
            rd = hrdata;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            bus(1'b1, a, d);
            if (a == 8'h18)
                mdl[6] = d & 8'h03;
            else if (a < 8'h18)
                mdl[a[4:2]] = d;
        end
    endtask
    task rc(input [7:0] a);
        begin
            bus(1'b0, a, 8'h00);
            check("rdata", rd, {24'h000000, (a > 8'h1C) ? 8'h00 : mdl[a[4:2]]});
        end
    endtask
    initial
    begin
        for (i = 0; i < 8; i = i + 1)
            mdl[i] = 8'h00;
        mdl[7] = 8'h01;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        for (i = 0; i < 9; i = i + 1)
            rc(i * 4);
        $display("test reset done");
        for (k = 0; k < 7; k = k + 1)
        begin
            wr(k * 4, $random(seed) & ((k == 6) ? 3 : 255));
            rc(k * 4);
        end
        rc(8'h18);
        for (k = 0; k < 7; k = k + 1)
            wr(k * 4, 8'h00);
        $display("test access done");
        for (k = 0; k < 4; k = k + 1)
        begin
            p0 = $random(seed);
            p1 = $random(seed);
            e = $random(seed);
            want <= p0;
            lag <= $random(seed);
            repeat (40) @(posedge clk_sys_i);
            wr(8'h04, e[7:0]);
            wr(8'h10, e[15:8]);
            wr(8'h08, 8'h00);
            wr(8'h14, 8'h00);
            want <= p1;
            repeat (40) @(posedge clk_sys_i);
            {mdl[5], mdl[2]} = (~p0 & p1 & ~e) | (p0 & ~p1 & e);
            rc(8'h08);
            rc(8'h14);
        end
        $display("test edges done");
        wr(8'h08, 8'h81);
        wr(8'h00, 8'h80);
        wr(8'h14, 8'h80);
        wr(8'h0C, 8'h80);
        for (k = 0; k < 4; k = k + 1)
        begin
            wr(8'h18, k);
            repeat (3) @(posedge clk_sys_i);
            #1;
            check("irq_l", irq_l, k == 3);
            check("irq_m", irq_m, 1'b0);
        end
        wr(8'h0C, 8'h81);
        wr(8'h14, 8'h01);
        repeat (3) @(posedge clk_sys_i);
        #1;
        check("irq_m", irq_m, 1'b1);
        wr(8'h18, 8'h07);
        repeat (3) @(posedge clk_sys_i);
        #1;
        check("cce", cce, 1'b1);
        mdl[7] = 8'h21;
        rc(8'h1C);
        $display("test irq done");
        for (k = 0; k < 2; k = k + 1)
        begin
            want <= 16'h0000;
            repeat (40) @(posedge clk_sys_i);
            wr(8'h0C, 8'h00);
            wr(8'h14, 8'h00);
            wr(8'h04, 8'h00);
            wr(8'h08, 8'h00);
            wr(8'h0C, 8'h08);
            wr(8'h00, 8'h01);
            wr(8'h18, k ? 8'h08 : 8'h07);
            repeat (3) @(posedge clk_sys_i);
            #1;
            check("osc", osc, k == 1);
            want <= 16'h0001;
            i = 0;
            while (cce !== 1'b1 && i < 4000)
            begin
                @(posedge clk_sys_i);
                #1;
                i = i + 1;
            end
            check("wake_time", i >= 2555 && i <= 2600, 1'b1);
            if (i >= 4000)
                complete_run;
            check("svc", svc, k == 0);
            mdl[2] = 8'h01;
            mdl[7] = k ? 8'h01 : 8'h11;
            rc(8'h08);
            rc(8'h1C);
        end
        $display("test wake done");
        complete_run;
    end
endmodule // multi_input_wakeup_irq_tb_top
